// *** src/mmpio_top.sv ***
// Memory-mapped parallel ports: two 8-bit ports, a 4-bit output, a 4-bit input.
// Assumes the core issues one access per cycle and pins are synchronous to clk.
// Port I has no register location here; its pins are never driven.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Port L bit: config/data 00 hi-z, 01 pull-up, 10 drive low, 11 high.
// - Port L data at D0, config at D1, pin levels read at D2.
// - All L bits wake; L7 modulator, L2/L1 comparator inputs, L0 comparator out.
// - Wakeup enable at C9; comparator and modulator enables in C C control.
// - Port G bits 0-5 bidirectional, bits 6-7 input only, same encoding.
// - Port G data at D4, config at D5, pin levels read at D6.
// - Port G config bits 6 and 7 ignore writes and read zero.
// - Writing one to G data bit 7 enters halt.
// - G alternates: serial in/clock/out, timer, interrupt.
// - Interrupt enable in status at EF; timer and serial select at EE.
// - Four-bit output port D, preset high at reset, data at DC.
// - Four-bit input port never drives its pins.
// - Every mapped bit supports test; set and clear change only the writable registers, not the pin levels at D2/D6.
// - Reset clears L/G data and config, port D drives all high.
module mmpio_top #(
  parameter int unsigned port_width = 8,
  parameter int unsigned d_width = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Core data-space access
  input wire mmpio_pkg::mmpio_req_t req,
  output mmpio_pkg::mmpio_rsp_t rsp,
  // Alternate function sources
  input wire mmpio_pkg::mmpio_alt_t alt,
  // Port L pins
  input wire logic [7:0] port_l_in,
  output logic [7:0] port_l_out,
  output logic [7:0] port_l_oe,
  output logic [7:0] port_l_pull_up,
  // Port G pins
  input wire logic [7:0] port_g_in,
  output logic [7:0] port_g_out,
  output logic [7:0] port_g_oe,
  output logic [7:0] port_g_pull_up,
  // Port D and input-only port I
  output logic [3:0] port_d_out,
  // port I has no drive path
  input wire logic [3:0] port_i_in,
  // Alternate pin inputs, comparator enable and halt request towards other blocks
  output logic [7:0] multi_input_wakeup,
  output logic comparator_plus_input,
  output logic comparator_minus_input,
  output logic comparator_en,
  output logic external_interrupt_pin,
  output logic timer_pin_in,
  output logic serial_data_in,
  output logic serial_clock_pin_in,
  output logic halt_request
);
  if (port_width != 8) begin : g_check_port
    $error("mmpio_top serves only 8-bit ports");
  end
  if (d_width != 4) begin : g_check_d
    $error("mmpio_top serves only a 4-bit port D");
  end

  typedef struct packed {
    // Software-visible registers
    logic [7:0] wakeup_enable;
    logic [7:0] second_control;
    logic [7:0] port_l_data;
    logic [7:0] port_l_config;
    logic [7:0] port_g_data;
    logic [7:0] port_g_config;
    logic [3:0] port_d_data;
    logic [7:0] first_control;
    logic [7:0] processor_status;
    // Registered response
    mmpio_pkg::mmpio_rsp_t rsp;
    // Registered pin drive
    logic [7:0] l_out;
    logic [7:0] l_oe;
    logic [7:0] l_pu;
    logic [7:0] g_out;
    logic [7:0] g_oe;
    logic [7:0] g_pu;
    // Registered pin samples and comparator enable for other blocks
    logic [7:0] wake;
    logic cmp_plus;
    logic cmp_minus;
    logic cmp_en;
    logic ext_int;
    logic timer_in;
    logic ser_in;
    logic ser_clk_in;
    // One-cycle halt pulse
    logic halt;
  } mmpio_state_t;

  mmpio_state_t st;
  mmpio_state_t next_st;
  // Access decode
  logic [7:0] cur;
  logic we;
  logic [7:0] wval;
  logic hit;
  // Per-pin drive from the cells
  mmpio_pkg::mmpio_drive_t l_drv [8];
  mmpio_pkg::mmpio_drive_t g_drv [8];
  wire [7:0] l_drv_out;
  wire [7:0] l_drv_oe;
  wire [7:0] l_drv_pu;
  wire [7:0] g_drv_out;
  wire [7:0] g_drv_oe;
  wire [7:0] g_drv_pu;
  // Alternate overrides per pin
  logic [7:0] l_alt_en;
  logic [7:0] l_alt_out;
  logic [7:0] l_alt_oe;
  logic [7:0] g_alt_en;
  logic [7:0] g_alt_out;
  logic [7:0] g_alt_oe;

  // Readback mux; pins are read live, not from data latches
  always_comb begin
    hit = 1'b1;
    cur = 8'h00;
    unique case (req.addr)
      mmpio_pkg::addr_wakeup_enable: cur = st.wakeup_enable;
      mmpio_pkg::addr_second_control: cur = st.second_control;
      mmpio_pkg::addr_port_l_data: cur = st.port_l_data;
      mmpio_pkg::addr_port_l_config: cur = st.port_l_config;
      mmpio_pkg::addr_port_l_pins: cur = port_l_in;
      mmpio_pkg::addr_port_g_data: cur = st.port_g_data;
      mmpio_pkg::addr_port_g_config: cur = st.port_g_config & mmpio_pkg::g_config_mask;
      mmpio_pkg::addr_port_g_pins: cur = port_g_in;
      mmpio_pkg::addr_port_d_data: cur = {4'h0, st.port_d_data};
      mmpio_pkg::addr_first_control: cur = st.first_control;
      mmpio_pkg::addr_processor_status: cur = st.processor_status;
      default: begin
        hit = 1'b0;
        cur = 8'h00;
      end
    endcase
  end

  mmpio_bit_op u_bit_op (
    .op(req.op),
    .cur(cur),
    .wdata(req.wdata),
    .bit_sel(req.bit_sel),
    .we(we),
    .next_val(wval)
  );

  // Alternate function routing
  always_comb begin
    l_alt_en = 8'h00;
    l_alt_out = 8'h00;
    l_alt_oe = 8'h00;
    g_alt_en = 8'h00;
    g_alt_out = 8'h00;
    g_alt_oe = 8'h00;
    l_alt_en[mmpio_pkg::l_mod_bit] = st.second_control[mmpio_pkg::c2_modulator_en];
    l_alt_out[mmpio_pkg::l_mod_bit] = alt.modulator_output;
    l_alt_oe[mmpio_pkg::l_mod_bit] = 1'b1;
    l_alt_en[mmpio_pkg::l_cmp_out_bit] = st.second_control[mmpio_pkg::c2_comparator_out_en];
    l_alt_out[mmpio_pkg::l_cmp_out_bit] = alt.comparator_output;
    l_alt_oe[mmpio_pkg::l_cmp_out_bit] = 1'b1;
    // Comparator inputs must not be driven
    l_alt_en[mmpio_pkg::l_cmp_plus_bit] = st.second_control[mmpio_pkg::c2_comparator_en];
    l_alt_en[mmpio_pkg::l_cmp_minus_bit] = st.second_control[mmpio_pkg::c2_comparator_en];
    g_alt_en[mmpio_pkg::g_timer_bit] = st.first_control[mmpio_pkg::c1_timer_pin_en];
    g_alt_out[mmpio_pkg::g_timer_bit] = alt.timer_pin_out;
    g_alt_oe[mmpio_pkg::g_timer_bit] = alt.timer_pin_oe;
    g_alt_en[mmpio_pkg::g_serial_clk_bit] = st.first_control[mmpio_pkg::c1_serial_en];
    g_alt_out[mmpio_pkg::g_serial_clk_bit] = alt.serial_clock_out;
    g_alt_oe[mmpio_pkg::g_serial_clk_bit] = alt.serial_clock_oe;
    g_alt_en[mmpio_pkg::g_serial_out_bit] = st.first_control[mmpio_pkg::c1_serial_en];
    g_alt_out[mmpio_pkg::g_serial_out_bit] = alt.serial_data_out;
    g_alt_oe[mmpio_pkg::g_serial_out_bit] = 1'b1;
    // G6, G7 stay inputs; G0, G1 and G2 have no alternate drive and follow their config
  end

  // One pin cell per bit of each 8-bit port
  for (genvar i = 0; i < 8; i++) begin : g_pins
    mmpio_pin_cell u_l (
      .config_bit(st.port_l_config[i]),
      .data_bit(st.port_l_data[i]),
      .alt_en(l_alt_en[i]),
      .alt_out(l_alt_out[i]),
      .alt_oe(l_alt_oe[i]),
      .drive(l_drv[i])
    );
    mmpio_pin_cell u_g (
      .config_bit(st.port_g_config[i] & mmpio_pkg::g_config_mask[i]),
      .data_bit(st.port_g_data[i] & mmpio_pkg::g_config_mask[i]),
      .alt_en(g_alt_en[i]),
      .alt_out(g_alt_out[i]),
      .alt_oe(g_alt_oe[i]),
      .drive(g_drv[i])
    );
    // Unpack cell drives into per-port vectors
    assign l_drv_out[i] = l_drv[i].out;
    assign l_drv_oe[i] = l_drv[i].oe;
    assign l_drv_pu[i] = l_drv[i].pull_up;
    assign g_drv_out[i] = g_drv[i].out;
    assign g_drv_oe[i] = g_drv[i].oe;
    assign g_drv_pu[i] = g_drv[i].pull_up;
  end

  always_comb begin
    next_st = st;
    next_st.rsp.hit = hit && (req.op != mmpio_pkg::mmpio_op_none);
    next_st.rsp.rdata = cur;
    next_st.rsp.test_bit = cur[req.bit_sel];
    // Halt pulses for one cycle only
    next_st.halt = 1'b0;
    if (we && hit) begin
      unique case (req.addr)
        mmpio_pkg::addr_wakeup_enable: next_st.wakeup_enable = wval;
        mmpio_pkg::addr_second_control: next_st.second_control = wval;
        mmpio_pkg::addr_port_l_data: next_st.port_l_data = wval;
        mmpio_pkg::addr_port_l_config: next_st.port_l_config = wval;
        mmpio_pkg::addr_port_g_data: begin
          next_st.port_g_data = wval;
          next_st.halt = wval[mmpio_pkg::g_halt_bit];
        end
        mmpio_pkg::addr_port_g_config: next_st.port_g_config = wval & mmpio_pkg::g_config_mask;
        mmpio_pkg::addr_port_d_data: next_st.port_d_data = wval[3:0] & mmpio_pkg::d_mask;
        mmpio_pkg::addr_first_control: next_st.first_control = wval;
        mmpio_pkg::addr_processor_status: next_st.processor_status = wval;
        default: next_st.halt = 1'b0;
      endcase
    end

    next_st.l_out = l_drv_out;
    next_st.l_oe = l_drv_oe;
    next_st.l_pu = l_drv_pu;
    next_st.g_out = g_drv_out;
    next_st.g_oe = g_drv_oe;
    next_st.g_pu = g_drv_pu;

    // Pin samples reach other blocks one cycle late
    // wakeup gated by enables
    next_st.wake = port_l_in & st.wakeup_enable;
    next_st.cmp_plus = port_l_in[mmpio_pkg::l_cmp_plus_bit];
    next_st.cmp_minus = port_l_in[mmpio_pkg::l_cmp_minus_bit];
    next_st.cmp_en = st.second_control[mmpio_pkg::c2_comparator_en];
    next_st.ext_int = port_g_in[mmpio_pkg::g_ext_int_bit] &
      st.processor_status[mmpio_pkg::ps_ext_int_en];
    next_st.timer_in = port_g_in[mmpio_pkg::g_timer_bit];
    next_st.ser_in = port_g_in[mmpio_pkg::g_serial_in_bit];
    next_st.ser_clk_in = port_g_in[mmpio_pkg::g_serial_clk_bit];
  end

  // Single register stage holds every piece of state
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
      st.port_d_data <= mmpio_pkg::rst_port_d;
    end else begin
      st <= next_st;
    end
  end

  assign rsp = st.rsp;
  assign port_l_out = st.l_out;
  assign port_l_oe = st.l_oe;
  assign port_l_pull_up = st.l_pu;
  assign port_g_out = st.g_out;
  assign port_g_oe = st.g_oe;
  assign port_g_pull_up = st.g_pu;

  assign port_d_out = st.port_d_data;
  assign multi_input_wakeup = st.wake;
  assign comparator_plus_input = st.cmp_plus;
  assign comparator_minus_input = st.cmp_minus;
  assign comparator_en = st.cmp_en;
  assign external_interrupt_pin = st.ext_int;
  assign timer_pin_in = st.timer_in;
  assign serial_data_in = st.ser_in;
  assign serial_clock_pin_in = st.ser_clk_in;
  assign halt_request = st.halt;
endmodule : mmpio_top
`default_nettype wire

// *** src/mmpio_pkg.sv ***
// Package for the memory-mapped port block: addresses, field positions, carriers.
// Assumes one instruction clock and a synchronous active-high reset.
package mmpio_pkg;
  localparam logic [7:0] addr_wakeup_enable = 8'hc9;
  localparam logic [7:0] addr_second_control = 8'hcc;
  localparam logic [7:0] addr_port_l_data = 8'hd0;
  localparam logic [7:0] addr_port_l_config = 8'hd1;
  localparam logic [7:0] addr_port_l_pins = 8'hd2;
  localparam logic [7:0] addr_port_g_data = 8'hd4;
  localparam logic [7:0] addr_port_g_config = 8'hd5;
  localparam logic [7:0] addr_port_g_pins = 8'hd6;
  localparam logic [7:0] addr_port_d_data = 8'hdc;
  localparam logic [7:0] addr_first_control = 8'hee;
  localparam logic [7:0] addr_processor_status = 8'hef;

  // Reset values
  localparam logic [7:0] rst_byte = 8'h00;
  localparam logic [3:0] rst_port_d = 4'hf;
  // Second port: pins 6 and 7 are input only
  localparam logic [7:0] g_config_mask = 8'h3f;
  localparam logic [3:0] d_mask = 4'hf;

  // Alternate-function enable bit positions and pin positions
  localparam int unsigned bit_l_pins = 8;
  localparam int unsigned c2_comparator_en = 0;
  localparam int unsigned c2_comparator_out_en = 1;
  localparam int unsigned c2_modulator_en = 2;
  localparam int unsigned c1_timer_pin_en = 0;
  localparam int unsigned c1_serial_en = 1;
  localparam int unsigned ps_ext_int_en = 1;
  localparam int unsigned g_halt_bit = 7;
  localparam int unsigned l_mod_bit = 7;
  localparam int unsigned l_cmp_plus_bit = 2;
  localparam int unsigned l_cmp_minus_bit = 1;
  localparam int unsigned l_cmp_out_bit = 0;
  localparam int unsigned g_timer_bit = 3;
  localparam int unsigned g_serial_clk_bit = 5;
  localparam int unsigned g_serial_out_bit = 4;
  localparam int unsigned g_ext_int_bit = 0;
  localparam int unsigned g_serial_in_bit = 6;

  // Core access operations
  typedef enum logic [2:0] {
    mmpio_op_none,
    mmpio_op_write,
    mmpio_op_read,
    mmpio_op_set,
    mmpio_op_clear,
    mmpio_op_test
  } mmpio_op_t;

  typedef struct packed {
    mmpio_op_t op;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] bit_sel;
  } mmpio_req_t;

  typedef struct packed {
    logic hit;
    logic [7:0] rdata;
    logic test_bit;
  } mmpio_rsp_t;

  // Values that alternate functions want on pins
  typedef struct packed {
    logic modulator_output;
    logic comparator_output;
    logic timer_pin_out;
    logic timer_pin_oe;
    logic serial_clock_out;
    logic serial_clock_oe;
    logic serial_data_out;
  } mmpio_alt_t;

  // One pin's drive
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
  } mmpio_drive_t;
endpackage : mmpio_pkg

// *** src/mmpio_pin_cell.sv ***
// One configurable port bit: config/data decode with optional alternate override.
// Assumes config and data are the registered port bits.
`timescale 1ns/1ns
`default_nettype none
module mmpio_pin_cell (
  // Register bits
  input wire logic config_bit,
  input wire logic data_bit,
  // Alternate function
  input wire logic alt_en,
  input wire logic alt_out,
  input wire logic alt_oe,
  // Pin drive
  output mmpio_pkg::mmpio_drive_t drive
);
  always_comb begin
    drive.oe = config_bit;
    drive.out = data_bit;
    drive.pull_up = !config_bit && data_bit;
    if (alt_en) begin
      drive.oe = alt_oe;
      drive.out = alt_out;
      drive.pull_up = 1'b0;
    end
  end
endmodule : mmpio_pin_cell
`default_nettype wire

// *** src/mmpio_bit_op.sv ***
// Byte read-modify-write for the core's write and single-bit set and clear.
// Assumes the caller supplies the current register value.
`timescale 1ns/1ns
`default_nettype none
module mmpio_bit_op (
  // Request
  input wire mmpio_pkg::mmpio_op_t op,
  input wire logic [7:0] cur,
  input wire logic [7:0] wdata,
  input wire logic [2:0] bit_sel,
  // Result
  output logic we,
  output logic [7:0] next_val
);
  always_comb begin
    we = 1'b0;
    next_val = cur;
    unique case (op)
      mmpio_pkg::mmpio_op_write: begin
        we = 1'b1;
        next_val = wdata;
      end
      mmpio_pkg::mmpio_op_set: begin
        we = 1'b1;
        next_val[bit_sel] = 1'b1;
      end
      mmpio_pkg::mmpio_op_clear: begin
        we = 1'b1;
        next_val[bit_sel] = 1'b0;
      end
      default: begin
        we = 1'b0;
      end
    endcase
  end
endmodule : mmpio_bit_op
`default_nettype wire

// *** sim/mmpio_pin_load.sv ***
// Board loads on one port: resolves pin levels from device drive and bench sources.
// Assumes the bench gives external levels and which lines it drives.
`timescale 1ns/1ns
`default_nettype none
module mmpio_pin_load (
  // Clock
  input wire logic clk,
  // Device drive
  input wire logic [7:0] out,
  input wire logic [7:0] oe,
  input wire logic [7:0] pull_up,
  // External sources
  input wire logic [7:0] ext,
  input wire logic [7:0] ext_en,
  // Resolved level
  output logic [7:0] level
);
  logic [7:0] float_pat = 8'h55;
  // Floating lines wander so a stale value never matches by luck
  always @(posedge clk) float_pat <= ~float_pat;
  // drive beats load, pull-up beats float
  assign level = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pull_up | float_pat));
endmodule : mmpio_pin_load
`default_nettype wire

// *** sim/mmpio_assertions.sv ***
// Checker on the port block's core access and pin drive.
// Assumes it is bound into mmpio_top.
`timescale 1ns/1ns
`default_nettype none
module mmpio_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Core access
  input wire mmpio_pkg::mmpio_req_t req,
  input wire mmpio_pkg::mmpio_rsp_t rsp,
  // Pins
  input wire logic [7:0] port_l_oe,
  input wire logic [7:0] port_g_oe,
  input wire logic [3:0] port_d_out,
  input wire logic halt_request
);
  logic wr;
  logic rd;
  assign wr = req.op == mmpio_pkg::mmpio_op_write;
  assign rd = req.op == mmpio_pkg::mmpio_op_read;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Bits 6:3 carry no alternate, so config shows directly
  a_l_config_drive: assert property (wr && req.addr == mmpio_pkg::addr_port_l_config ##1
    req.op == mmpio_pkg::mmpio_op_none |=> port_l_oe[6:3] == $past(req.wdata[6:3], 2))
    else $error("port L drive does not follow config");
  a_g_input_only: assert property (port_g_oe[7:6] == 2'h0)
    else $error("port G input-only pin driven");
  a_g_config_zero: assert property (rd && req.addr == mmpio_pkg::addr_port_g_config
    |=> rsp.rdata[7:6] == 2'h0) else $error("port G config top bits not zero");
  a_halt_on_write: assert property (wr && req.addr == mmpio_pkg::addr_port_g_data
    && req.wdata[7] |=> halt_request) else $error("halt not requested");
  a_halt_cause: assert property (halt_request |-> $past(req.addr) == 8'hd4)
    else $error("halt without port G data access");
  a_reset_preset: assert property ($fell(reset) |-> port_d_out == 4'hf
    && port_l_oe == 8'h00) else $error("reset state wrong");
  a_miss_unmapped: assert property (req.op != mmpio_pkg::mmpio_op_none && req.addr == 8'h00
    |=> !rsp.hit && rsp.rdata == 8'h00) else $error("unmapped access answered");
  a_test_result: assert property ($past(req.op) == mmpio_pkg::mmpio_op_test
    |-> rsp.test_bit == rsp.rdata[$past(req.bit_sel)]) else $error("test bit wrong");
  c_halt: cover property (halt_request);
  c_test: cover property ($past(req.op) == mmpio_pkg::mmpio_op_test && rsp.test_bit);
  c_miss: cover property (rd && req.addr == 8'h00);
endmodule : mmpio_assertions
bind mmpio_top mmpio_assertions u_chk (.clk(clk), .reset(reset), .req(req), .rsp(rsp),
  .port_l_oe(port_l_oe), .port_g_oe(port_g_oe), .port_d_out(port_d_out),
  .halt_request(halt_request));
`default_nettype wire

// *** sim/tb.sv ***
// Bench for the port block: core accesses on req/rsp, pins through load models.
// Assumes a 125 MHz clock and the checker bound into the block.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  mmpio_pkg::mmpio_req_t req = '0;
  mmpio_pkg::mmpio_rsp_t rsp, r;
  mmpio_pkg::mmpio_alt_t alt = '0;
  logic [7:0] l_in, l_out, l_oe, l_pu, g_in, g_out, g_oe, g_pu, wake;
  logic [7:0] l_ext = 8'h0f;
  logic [7:0] g_ext = 8'h00;
  logic [3:0] d_out;
  logic cmp_p, cmp_m, cmp_en, ext_int, tmr_in, ser_in, ser_clk, halt, h;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] regs [10] = '{8'hc9, 8'hcc, 8'hd0, 8'hd1, 8'hd2, 8'hd4, 8'hd5, 8'hd6, 8'hee, 8'hef};
  logic [7:0] rw [6] = '{8'hc9, 8'hd0, 8'hd1, 8'hd4, 8'hee, 8'hef};
  initial forever #4 clk = ~clk;
  mmpio_top dut (.clk(clk), .reset(reset), .req(req), .rsp(rsp), .alt(alt),
    .port_l_in(l_in), .port_l_out(l_out), .port_l_oe(l_oe), .port_l_pull_up(l_pu),
    .port_g_in(g_in), .port_g_out(g_out), .port_g_oe(g_oe), .port_g_pull_up(g_pu),
    .port_d_out(d_out), .port_i_in(4'h0), .multi_input_wakeup(wake),
    .comparator_plus_input(cmp_p), .comparator_minus_input(cmp_m), .comparator_en(cmp_en),
    .external_interrupt_pin(ext_int), .timer_pin_in(tmr_in), .serial_data_in(ser_in),
    .serial_clock_pin_in(ser_clk), .halt_request(halt));
  mmpio_pin_load u_l (.clk(clk), .out(l_out), .oe(l_oe), .pull_up(l_pu), .ext(l_ext),
    .ext_en(8'hff), .level(l_in));
  mmpio_pin_load u_g (.clk(clk), .out(g_out), .oe(g_oe), .pull_up(g_pu), .ext(g_ext),
    .ext_en(8'hff), .level(g_in));
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic acc(input mmpio_pkg::mmpio_op_t op, input logic [7:0] a, d, input logic [2:0] b);
    @(posedge clk);
    #1;
    req = '{op, a, d, b};
    @(posedge clk);
    #1;
    req.op = mmpio_pkg::mmpio_op_none;
    r = rsp;
    h = halt;
  endtask : acc
  task automatic chk(input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    acc(mmpio_pkg::mmpio_op_write, a, d, 3'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, exp);
    acc(mmpio_pkg::mmpio_op_read, a, 8'h00, 3'h0);
    chk({7'h0, r.hit}, 8'h01);
    chk(r.rdata, exp);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  // Hang guard, run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    chk({4'h0, d_out}, 8'h0f);
    chk(l_oe | g_oe, 8'h00);
    // Tri-stated L pins show the load's 0f
    foreach (regs[i]) rd(regs[i], (regs[i] == 8'hd2) ? 8'h0f : 8'h00);
    rd(mmpio_pkg::addr_port_d_data, 8'h0f);
    foreach (rw[i]) begin
      wr(rw[i], 8'h5a);
      rd(rw[i], 8'h5a);
      wr(rw[i], 8'h00);
    end
    acc(mmpio_pkg::mmpio_op_set, 8'hd5, 8'h00, 3'h6);
    rd(8'hd5, 8'h00);
    wr(8'hd5, 8'hff);
    rd(8'hd5, 8'h3f);
    settle(1);
    chk(g_oe, 8'h3f);
    // Each nibble pair covers all four config/data codes
    wr(8'hd1, 8'hcc);
    wr(8'hd0, 8'haa);
    settle(1);
    chk(l_oe, 8'hcc);
    chk(l_out & l_oe, 8'h88);
    chk(l_pu, 8'h22);
    rd(8'hd2, 8'h8b);
    wr(8'hd2, 8'h00);
    rd(8'hd2, 8'h8b);
    g_ext = 8'h50;
    wr(8'hd5, 8'h0c);
    wr(8'hd4, 8'h0a);
    settle(1);
    chk(g_oe, 8'h0c);
    chk(g_pu, 8'h02);
    rd(8'hd6, 8'h58);
    acc(mmpio_pkg::mmpio_op_set, 8'hd0, 8'h00, 3'h0);
    rd(8'hd0, 8'hab);
    acc(mmpio_pkg::mmpio_op_clear, 8'hd0, 8'h00, 3'h7);
    rd(8'hd0, 8'h2b);
    acc(mmpio_pkg::mmpio_op_test, 8'hd0, 8'h00, 3'h5);
    chk({r.rdata[7:1], r.test_bit}, 8'h2b);
    acc(mmpio_pkg::mmpio_op_test, 8'hd0, 8'h00, 3'h4);
    chk({7'h0, r.test_bit}, 8'h00);
    wr(8'hd4, 8'h80);
    chk({7'h0, h}, 8'h01);
    wr(8'hd4, 8'h00);
    chk({7'h0, h}, 8'h00);
    acc(mmpio_pkg::mmpio_op_set, 8'hd4, 8'h00, 3'h7);
    chk({7'h0, h}, 8'h01);
    wr(8'hdc, 8'ha5);
    rd(8'hdc, 8'h05);
    settle(1);
    chk({4'h0, d_out}, 8'h05);
    acc(mmpio_pkg::mmpio_op_read, 8'h00, 8'h00, 3'h0);
    chk({r.rdata[7:1], r.hit}, 8'h00);
    // Comparator releases L2, so the load's level shows there
    alt.modulator_output = 1'b1;
    wr(8'hcc, 8'h05);
    settle(2);
    chk({5'h0, l_out[7], cmp_p, cmp_m}, 8'h07);
    chk({7'h0, cmp_en}, 8'h01);
    rd(8'hd2, 8'h8f);
    alt.modulator_output = 1'b0;
    settle(2);
    chk({7'h0, l_out[7]}, 8'h00);
    alt.comparator_output = 1'b1;
    wr(8'hcc, 8'h02);
    wr(8'hc9, 8'h81);
    settle(2);
    chk(wake, 8'h01);
    chk({6'h0, l_oe[0], l_out[0]}, 8'h03);
    alt.timer_pin_oe = 1'b1;
    alt.timer_pin_out = 1'b1;
    alt.serial_data_out = 1'b1;
    wr(8'hee, 8'h03);
    settle(1);
    chk({6'h0, g_oe[3], g_out[3]}, 8'h03);
    chk({4'h0, g_oe[5:4], g_out[5:4]}, 8'h05);
    g_ext = 8'h51;
    wr(8'hef, 8'h02);
    settle(2);
    chk({4'h0, ext_int, ser_in, ser_clk, tmr_in}, 8'h0d);
    wr(8'hef, 8'h00);
    settle(1);
    chk({7'h0, ext_int}, 8'h00);
    reset = 1'b1;
    settle(2);
    reset = 1'b0;
    chk({4'h0, d_out}, 8'h0f);
    chk(l_oe, 8'h00);
    rd(8'hd0, 8'h00);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
